// [inc/ifsb_pkg.sv]
/*
 * Shared constants and types of the interrupt flag status bank: register
 * offsets, flag bit positions, implemented-bit masks and the bus carrier.
 * Assumes a single 125 MHz clock domain and same-clock event sources.
 */
package ifsb_pkg;

	localparam int unsigned   DATA_W        = 16;
	localparam int unsigned   ADDR_W        = 4;
	localparam logic [3:0]    OFF_GROUP_ONE = 4'h0;
	localparam logic [3:0]    OFF_GROUP_TWO = 4'h1;
	localparam logic [15:0]   RST_FLAGS     = 16'h0000;
	localparam logic [15:0]   RST_RD_DATA   = 16'h0000;
	// Bit 2 of group one and bit 13 of group two are not built
	localparam logic [15:0]   IMPL_ONE      = 16'hfffb;
	localparam logic [15:0]   IMPL_TWO      = 16'hdfff;

	// Group one bit positions
	localparam int unsigned   B1_UART_TX    = 15;
	localparam int unsigned   B1_UART_RX    = 14;
	localparam int unsigned   B1_EXT_TWO    = 13;
	localparam int unsigned   B1_TIMER_FIVE = 12;
	localparam int unsigned   B1_TIMER_FOUR = 11;
	localparam int unsigned   B1_CMP_FOUR   = 10;
	localparam int unsigned   B1_CMP_THREE  = 9;
	localparam int unsigned   B1_DMA_TWO    = 8;
	localparam int unsigned   B1_CAPT_EIGHT = 7;
	localparam int unsigned   B1_CAPT_SEVEN = 6;
	localparam int unsigned   B1_ADC_TWO    = 5;
	localparam int unsigned   B1_EXT_ONE    = 4;
	localparam int unsigned   B1_PIN_CHANGE = 3;
	localparam int unsigned   B1_UNUSED     = 2;
	localparam int unsigned   B1_I2C_MASTER = 1;
	localparam int unsigned   B1_I2C_SLAVE  = 0;
	// Group two bit positions
	localparam int unsigned   B2_TIMER_SIX  = 15;
	localparam int unsigned   B2_DMA_FOUR   = 14;
	localparam int unsigned   B2_UNUSED     = 13;
	localparam int unsigned   B2_CMP_EIGHT  = 12;
	localparam int unsigned   B2_CMP_SEVEN  = 11;
	localparam int unsigned   B2_CMP_SIX    = 10;
	localparam int unsigned   B2_CMP_FIVE   = 9;
	localparam int unsigned   B2_CAPT_SIX   = 8;
	localparam int unsigned   B2_CAPT_FIVE  = 7;
	localparam int unsigned   B2_CAPT_FOUR  = 6;
	localparam int unsigned   B2_CAPT_THREE = 5;
	localparam int unsigned   B2_DMA_THREE  = 4;
	localparam int unsigned   B2_CAN_EVENT  = 3;
	localparam int unsigned   B2_CAN_RX     = 2;
	localparam int unsigned   B2_SPI_EVENT  = 1;
	localparam int unsigned   B2_SPI_ERROR  = 0;

	// Field order is bit order, msb first; used for events and for flags
	typedef struct packed {
		logic uart_two_tx_request_flag;
		logic uart_two_rx_request_flag;
		logic ext_input_two_request_flag;
		logic timer_five_request_flag;
		logic timer_four_request_flag;
		logic compare_four_request_flag;
		logic compare_three_request_flag;
		logic dma_chan_two_done_flag;
		logic capture_eight_request_flag;
		logic capture_seven_request_flag;
		logic adc_two_done_flag;
		logic ext_input_one_request_flag;
		logic pin_change_request_flag;
		logic unused_bit_two;
		logic i2c_one_master_event_flag;
		logic i2c_one_slave_event_flag;
	} ifsb_grp_one_t;

	typedef struct packed {
		logic timer_six_request_flag;
		logic dma_chan_four_done_flag;
		logic unused_bit_thirteen;
		logic compare_eight_request_flag;
		logic compare_seven_request_flag;
		logic compare_six_request_flag;
		logic compare_five_request_flag;
		logic capture_six_request_flag;
		logic capture_five_request_flag;
		logic capture_four_request_flag;
		logic capture_three_request_flag;
		logic dma_chan_three_done_flag;
		logic can_one_event_flag;
		logic can_one_rx_ready_flag;
		logic spi_two_event_flag;
		logic spi_two_error_flag;
	} ifsb_grp_two_t;

	typedef struct packed {
		logic               wr;
		logic               rd;
		logic [ADDR_W-1:0]  addr;
		logic [DATA_W-1:0]  wdata;
	} ifsb_bus_req_t;

	typedef struct packed {
		logic flag;
	} ifsb_cell_state_t;

	typedef struct packed {
		logic [DATA_W-1:0] rd_data_ff;
	} ifsb_bank_state_t;

endpackage

// [design/ifsb_flag_cell.sv]
/*
 * One sticky interrupt flag: set by its source, written by software.
 * Assumes the set input is a same-clock level or pulse from the source.
 */
`timescale 1ns/1ns
module ifsb_flag_cell
	import ifsb_pkg::*;
#(
	parameter bit IMPL = 1'b1
) (
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic set_evt,
	input  wire logic wr_en,
	input  wire logic wr_val,
	output      logic flag
);

	ifsb_cell_state_t state_ff;
	ifsb_cell_state_t nxt_state;

	always_comb begin
		nxt_state = state_ff;
		if (wr_en) begin
			nxt_state.flag = wr_val;
		end
		// Source wins over a coinciding software clear
		if (set_evt) begin
			nxt_state.flag = 1'b1;
		end
		// Unbuilt bit never stores anything
		if (!IMPL) begin
			nxt_state.flag = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign flag = state_ff.flag;

endmodule

// [design/ifsb_flag_bank.sv]
/*
 * Two 16-bit interrupt flag status registers with a plain register port.
 * Assumes event sources run on ref_clk and the bus master never waits.
 */
// Strobed register access and the placing of the registers were chosen for this implementation.
// What this block does
// - Group one bits 15..8: uart2 tx, uart2 rx, ext2, t5, t4, oc4, oc3, dma2
// - Group one bits 7..3: ic8, ic7, adc2 done, ext1, pin change
// - Group one bit 1 i2c1 master event, bit 0 i2c1 slave event
// - Group one bit 2 is not built and always reads zero
// - Group two bit 15 timer6, bit 14 dma4 done
// - Group two bit 13 is not built and always reads zero
// - Group two bits 12..9: output compare 8, 7, 6, 5
// - Group two bits 8..5 capture 6..3, bit 4 dma3 done
// - Group two bit 3 holds the can1 general event flag
// - A flag reads one after its request or a write of one, zero after reset or a write of zero with no request in that cycle
// - Group two bit 2 can1 rx ready, bit 1 spi2 event, bit 0 spi2 error
`timescale 1ns/1ns
module ifsb_flag_bank
	import ifsb_pkg::*;
#(
	parameter int unsigned REG_W = DATA_W
) (
	input  wire logic          ref_clk,
	input  wire logic          resetn,
	input  wire ifsb_bus_req_t bus_req,
	output      logic [15:0]   rd_data,
	input  wire ifsb_grp_one_t evt_one,
	input  wire ifsb_grp_two_t evt_two,
	output      ifsb_grp_one_t flags_one,
	output      ifsb_grp_two_t flags_two
);

	if (REG_W != 16) begin : g_width_check
		$error("ifsb_flag_bank only supports 16-bit registers");
	end

	ifsb_bank_state_t state_ff;
	ifsb_bank_state_t nxt_state;

	logic [15:0] evt_one_v;
	logic [15:0] evt_two_v;
	logic [15:0] flags_one_v;
	logic [15:0] flags_two_v;
	logic        wr_one;
	logic        wr_two;
	logic        rd_one;
	logic        rd_two;

	assign evt_one_v = evt_one;
	assign evt_two_v = evt_two;
	assign wr_one    = bus_req.wr && (bus_req.addr == OFF_GROUP_ONE);
	assign wr_two    = bus_req.wr && (bus_req.addr == OFF_GROUP_TWO);
	assign rd_one    = bus_req.rd && (bus_req.addr == OFF_GROUP_ONE);
	assign rd_two    = bus_req.rd && (bus_req.addr == OFF_GROUP_TWO);

	// Enables and priorities live elsewhere, so a set never looks at them
	for (genvar i = 0; i < 16; i++) begin : g_cells
		ifsb_flag_cell #(
			.IMPL (IMPL_ONE[i])
		) u_one (
			.ref_clk (ref_clk),
			.resetn  (resetn),
			.set_evt (evt_one_v[i]),
			.wr_en   (wr_one),
			.wr_val  (bus_req.wdata[i]),
			.flag    (flags_one_v[i])
		);
		ifsb_flag_cell #(
			.IMPL (IMPL_TWO[i])
		) u_two (
			.ref_clk (ref_clk),
			.resetn  (resetn),
			.set_evt (evt_two_v[i]),
			.wr_en   (wr_two),
			.wr_val  (bus_req.wdata[i]),
			.flag    (flags_two_v[i])
		);
	end

	// Struct layout places every flag at its bit
	assign flags_one = flags_one_v;
	assign flags_two = flags_two_v;

	always_comb begin
		nxt_state = state_ff;
		// Data stand for one cycle only; idle cycles and unmapped reads give zero
		nxt_state.rd_data_ff = RST_RD_DATA;
		if (rd_one) begin
			nxt_state.rd_data_ff = flags_one_v & IMPL_ONE;
		end else if (rd_two) begin
			nxt_state.rd_data_ff = flags_two_v & IMPL_TWO;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign rd_data = state_ff.rd_data_ff;

	// Checks below watch flag placement, readback and the set/clear order

	a_uart_tx_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.uart_two_tx_request_flag |=> flags_one_v[B1_UART_TX]
	) else $error("uart2 tx event did not set group one bit 15");

	a_dma_two_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.dma_chan_two_done_flag && !wr_one
		|=> flags_one_v[B1_DMA_TWO] && flags_one.dma_chan_two_done_flag
	) else $error("dma2 done event did not set group one bit 8");

	a_capt_eight_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.capture_eight_request_flag ##1 rd_one
		|=> rd_data[B1_CAPT_EIGHT]
	) else $error("capture 8 flag not read back at group one bit 7");

	a_pin_change_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.pin_change_request_flag |=> flags_one_v[B1_PIN_CHANGE]
	) else $error("pin change event did not set group one bit 3");

	a_i2c_master_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.i2c_one_master_event_flag ##1 rd_one
		|=> rd_data[B1_I2C_MASTER]
	) else $error("i2c1 master flag not read back at group one bit 1");

	a_i2c_slave_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.i2c_one_slave_event_flag |=> flags_one_v[B1_I2C_SLAVE]
	) else $error("i2c1 slave event did not set group one bit 0");

	a_one_gap_zero: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		(evt_one.unused_bit_two || wr_one) ##1 rd_one
		|=> !rd_data[B1_UNUSED] && !flags_one_v[B1_UNUSED]
	) else $error("group one bit 2 did not read zero");

	a_timer_six_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.timer_six_request_flag ##1 rd_two
		|=> rd_data[B2_TIMER_SIX]
	) else $error("timer6 flag not read back at group two bit 15");

	a_dma_four_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.dma_chan_four_done_flag |=> flags_two_v[B2_DMA_FOUR]
	) else $error("dma4 done event did not set group two bit 14");

	a_two_gap_zero: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		(evt_two.unused_bit_thirteen || wr_two) ##1 rd_two
		|=> !rd_data[B2_UNUSED] && !flags_two_v[B2_UNUSED]
	) else $error("group two bit 13 did not read zero");

	a_cmp_eight_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.compare_eight_request_flag |=> flags_two_v[B2_CMP_EIGHT]
	) else $error("compare 8 event did not set group two bit 12");

	a_cmp_five_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.compare_five_request_flag ##1 rd_two
		|=> rd_data[B2_CMP_FIVE]
	) else $error("compare 5 flag not read back at group two bit 9");

	a_capt_six_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.capture_six_request_flag |=> flags_two_v[B2_CAPT_SIX]
	) else $error("capture 6 event did not set group two bit 8");

	a_dma_three_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.dma_chan_three_done_flag ##1 rd_two
		|=> rd_data[B2_DMA_THREE]
	) else $error("dma3 flag not read back at group two bit 4");

	a_can_event_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.can_one_event_flag |=> flags_two_v[B2_CAN_EVENT]
	) else $error("can1 event did not set group two bit 3");

	a_can_rx_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.can_one_rx_ready_flag ##1 rd_two
		|=> rd_data[B2_CAN_RX]
	) else $error("can1 rx flag not read back at group two bit 2");

	a_spi_error_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.spi_two_error_flag |=> flags_two_v[B2_SPI_ERROR]
	) else $error("spi2 error event did not set group two bit 0");

	a_flag_rise_cause: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		$rose(flags_one_v[B1_UART_TX])
		|-> $past(evt_one_v[B1_UART_TX]) || $past(wr_one)
	) else $error("group one flag rose with no request or write");

	a_flag_sticky: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		flags_two_v[B2_CAN_EVENT] && !(wr_two && !bus_req.wdata[B2_CAN_EVENT])
		|=> flags_two_v[B2_CAN_EVENT]
	) else $error("group two flag dropped without a software write");

	a_sw_clear: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		wr_one && (bus_req.wdata == 16'h0000) && (evt_one_v == 16'h0000)
		|=> (flags_one_v == 16'h0000)
		##1 (flags_one_v == 16'h0000 || $past(evt_one_v) != 16'h0000 || $past(wr_one))
	) else $error("write of zero did not clear group one");

	a_read_timing: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		rd_two |=> rd_data == ($past(flags_two_v) & IMPL_TWO) ##1 (rd_data == 16'h0000 || $past(bus_req.rd))
	) else $error("group two read data wrong or held too long");

	a_set_beats_clr: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		wr_two && !bus_req.wdata[B2_CAN_RX] && evt_two.can_one_rx_ready_flag
		|=> flags_two_v[B2_CAN_RX]
	) else $error("software clear beat a coinciding hardware set");

	// Remaining flag bits, one placement check each, then readback, write, hold and set/clear checks
	a_uart_rx_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.uart_two_rx_request_flag |=> flags_one_v[B1_UART_RX]
	) else $error("uart2 rx event did not set group one bit 14");

	a_ext_two_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.ext_input_two_request_flag |=> flags_one_v[B1_EXT_TWO]
	) else $error("ext input 2 event did not set group one bit 13");

	a_timer_five_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.timer_five_request_flag |=> flags_one_v[B1_TIMER_FIVE]
	) else $error("timer5 event did not set group one bit 12");

	a_timer_four_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.timer_four_request_flag |=> flags_one_v[B1_TIMER_FOUR]
	) else $error("timer4 event did not set group one bit 11");

	a_cmp_four_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.compare_four_request_flag |=> flags_one_v[B1_CMP_FOUR]
	) else $error("compare 4 event did not set group one bit 10");

	a_cmp_three_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.compare_three_request_flag |=> flags_one_v[B1_CMP_THREE]
	) else $error("compare 3 event did not set group one bit 9");

	a_capt_seven_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.capture_seven_request_flag |=> flags_one_v[B1_CAPT_SEVEN]
	) else $error("capture 7 event did not set group one bit 6");

	a_adc_two_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.adc_two_done_flag |=> flags_one_v[B1_ADC_TWO]
	) else $error("adc2 done event did not set group one bit 5");

	a_ext_one_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_one.ext_input_one_request_flag |=> flags_one_v[B1_EXT_ONE]
	) else $error("ext input 1 event did not set group one bit 4");

	a_cmp_seven_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.compare_seven_request_flag |=> flags_two_v[B2_CMP_SEVEN]
	) else $error("compare 7 event did not set group two bit 11");

	a_cmp_six_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.compare_six_request_flag |=> flags_two_v[B2_CMP_SIX]
	) else $error("compare 6 event did not set group two bit 10");

	a_capt_five_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.capture_five_request_flag |=> flags_two_v[B2_CAPT_FIVE]
	) else $error("capture 5 event did not set group two bit 7");

	a_capt_four_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.capture_four_request_flag |=> flags_two_v[B2_CAPT_FOUR]
	) else $error("capture 4 event did not set group two bit 6");

	a_capt_three_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.capture_three_request_flag |=> flags_two_v[B2_CAPT_THREE]
	) else $error("capture 3 event did not set group two bit 5");

	a_spi_event_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		evt_two.spi_two_event_flag |=> flags_two_v[B2_SPI_EVENT]
	) else $error("spi2 event did not set group two bit 1");

	a_read_one_data: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		rd_one |=> rd_data == ($past(flags_one_v) & IMPL_ONE)
	) else $error("group one read data wrong");

	a_unmapped_read: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		bus_req.rd && !rd_one && !rd_two |=> rd_data == RST_RD_DATA
	) else $error("unmapped read did not return zero");

	a_idle_rd_zero: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		!bus_req.rd |=> rd_data == RST_RD_DATA
	) else $error("read data not zero outside the read answer cycle");

	a_sw_set_bit: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		wr_two && bus_req.wdata[B2_TIMER_SIX] |=> flags_two_v[B2_TIMER_SIX]
	) else $error("write of one did not set group two bit 15");

	a_one_sticky: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		flags_one_v[B1_I2C_MASTER] && !(wr_one && !bus_req.wdata[B1_I2C_MASTER])
		|=> flags_one_v[B1_I2C_MASTER]
	) else $error("group one flag dropped without a software write");

	a_quiet_hold: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		!wr_one && (evt_one_v == 16'h0000) |=> $stable(flags_one_v)
	) else $error("group one changed with no write and no event");

	a_flag_fall_cause: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		$fell(flags_two_v[B2_SPI_ERROR]) |-> $past(wr_two)
	) else $error("group two flag fell with no software write");

	a_one_set_beats: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		wr_one && !bus_req.wdata[B1_PIN_CHANGE] && evt_one.pin_change_request_flag
		|=> flags_one_v[B1_PIN_CHANGE]
	) else $error("software clear beat a coinciding group one set");

endmodule

// [tb/ifsb_src_model.sv]
/*
 * Model of the peripheral event sources that feed the flag bank.
 * Assumes the bench commands one-cycle request bursts on ref_clk.
 */
`timescale 1ns/1ns
module ifsb_src_model
	import ifsb_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          resetn,
	input  wire logic          fire,
	input  wire logic [15:0]   mask_one,
	input  wire logic [15:0]   mask_two,
	output      ifsb_grp_one_t evt_one,
	output      ifsb_grp_two_t evt_two
);
	// Requests stand one cycle only, so a flag that fails to hold shows up
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			evt_one <= '0;
			evt_two <= '0;
		end else begin
			evt_one <= fire ? mask_one : '0;
			evt_two <= fire ? mask_two : '0;
		end
	end
endmodule

// [tb/ifsb_flag_bank_bench.sv]
/*
 * Self-checking bench for the interrupt flag status bank.
 * Assumes the single-clock register port and same-clock event sources.
 */
`timescale 1ns/1ns
module ifsb_flag_bank_bench
	import ifsb_pkg::*;
;
	logic          ref_clk;
	logic          resetn;
	ifsb_bus_req_t bus_req;
	logic [15:0]   rd_data;
	ifsb_grp_one_t evt_one;
	ifsb_grp_two_t evt_two;
	ifsb_grp_one_t flags_one;
	ifsb_grp_two_t flags_two;
	ifsb_grp_one_t e1;
	ifsb_grp_two_t e2;
	logic          fire;
	logic [15:0]   mask_one;
	logic [15:0]   mask_two;
	logic [15:0]   m1;
	logic [15:0]   m2;
	int            err_total;
	int            check_count;

	ifsb_flag_bank dut (.ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req),
		.rd_data(rd_data), .evt_one(evt_one), .evt_two(evt_two),
		.flags_one(flags_one), .flags_two(flags_two));
	ifsb_src_model src (.ref_clk(ref_clk), .resetn(resetn), .fire(fire),
		.mask_one(mask_one), .mask_two(mask_two), .evt_one(evt_one), .evt_two(evt_two));

	always #4 ref_clk = ~ref_clk;

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Write side clears or sets, events only ever add; set beats a write
	function automatic logic [15:0] after_wr(input logic [15:0] cur, input logic hit,
		input logic [15:0] wd, input logic [15:0] ev, input logic [15:0] impl);
		return ((hit ? wd : cur) | ev) & impl;
	endfunction

	// Starts just after a rising edge and returns just after one
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		bus_req.rd <= 1'b1;
		bus_req.addr <= a;
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
		#1;
		check("rd_data", rd_data, exp);
		@(posedge ref_clk);
	endtask

	// Event burst and optional write are taken at the same edge
	task automatic step(input logic wr, input logic [3:0] a, input logic [15:0] wd,
		input logic [15:0] v1, input logic [15:0] v2);
		@(posedge ref_clk);
		fire <= 1'b1;
		mask_one <= v1;
		mask_two <= v2;
		@(posedge ref_clk);
		fire <= 1'b0;
		bus_req.wr <= wr;
		bus_req.addr <= a;
		bus_req.wdata <= wd;
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
		m1 = after_wr(m1, wr && a == OFF_GROUP_ONE, wd, v1, IMPL_ONE);
		m2 = after_wr(m2, wr && a == OFF_GROUP_TWO, wd, v2, IMPL_TWO);
	endtask

	task automatic verify;
		rd_chk(OFF_GROUP_ONE, m1);
		rd_chk(OFF_GROUP_TWO, m2);
		#1;
		check("flags_one", flags_one, m1);
		check("flags_two", flags_two, m2);
		@(posedge ref_clk);
	endtask

	task automatic ev_case(input logic [15:0] v1, input logic [15:0] v2,
		input logic [15:0] x1, input logic [15:0] x2);
		step(1'b1, OFF_GROUP_ONE, 16'h0000, 16'h0000, 16'h0000);
		step(1'b1, OFF_GROUP_TWO, 16'h0000, v1, v2);
		// Read the group that saw events first, right behind the events
		if (v1 == 16'h0000) begin
			rd_chk(OFF_GROUP_TWO, x2);
			rd_chk(OFF_GROUP_ONE, x1);
		end else begin
			rd_chk(OFF_GROUP_ONE, x1);
			rd_chk(OFF_GROUP_TWO, x2);
		end
	endtask

	initial begin
		#100000;
		err_total++;
		print_verdict();
	end

	initial begin
		ref_clk = 1'b0;
		resetn = 1'b0;
		bus_req = '0;
		fire = 1'b0;
		mask_one = '0;
		mask_two = '0;
		m1 = '0;
		m2 = '0;
		err_total = 0;
		check_count = 0;
		void'($urandom(48));
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		verify();
		rd_chk(4'h9, 16'h0000);
		$display("test reset done");

		e1 = '{uart_two_tx_request_flag: 1'b1, dma_chan_two_done_flag: 1'b1, default: 1'b0};
		ev_case(e1, '0, 16'h8100, 16'h0000);
		e1 = '{capture_eight_request_flag: 1'b1, adc_two_done_flag: 1'b1,
			pin_change_request_flag: 1'b1, default: 1'b0};
		ev_case(e1, '0, 16'h00a8, 16'h0000);
		e1 = '{i2c_one_master_event_flag: 1'b1, i2c_one_slave_event_flag: 1'b1,
			unused_bit_two: 1'b1, default: 1'b0};
		ev_case(e1, '0, 16'h0003, 16'h0000);
		e2 = '{timer_six_request_flag: 1'b1, dma_chan_four_done_flag: 1'b1,
			unused_bit_thirteen: 1'b1, default: 1'b0};
		ev_case('0, e2, 16'h0000, 16'hc000);
		e2 = '{compare_eight_request_flag: 1'b1, compare_six_request_flag: 1'b1,
			compare_five_request_flag: 1'b1, default: 1'b0};
		ev_case('0, e2, 16'h0000, 16'h1600);
		e2 = '{capture_five_request_flag: 1'b1, dma_chan_three_done_flag: 1'b1, default: 1'b0};
		ev_case('0, e2, 16'h0000, 16'h0090);
		e2 = '{can_one_event_flag: 1'b1, default: 1'b0};
		ev_case('0, e2, 16'h0000, 16'h0008);
		rd_chk(OFF_GROUP_TWO, 16'h0008);
		e2 = '{can_one_rx_ready_flag: 1'b1, spi_two_event_flag: 1'b1,
			spi_two_error_flag: 1'b1, default: 1'b0};
		ev_case('0, e2, 16'h0000, 16'h0007);
		$display("test named sources done");

		step(1'b1, OFF_GROUP_ONE, 16'hffff, 16'h0000, 16'h0000);
		step(1'b1, OFF_GROUP_TWO, 16'hffff, 16'h0000, 16'h0000);
		rd_chk(OFF_GROUP_ONE, 16'hfffb);
		rd_chk(OFF_GROUP_TWO, 16'hdfff);
		step(1'b1, 4'h7, 16'h0000, 16'h0000, 16'h0000);
		verify();
		rd_chk(4'h7, 16'h0000);
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		m1 = '0;
		m2 = '0;
		verify();
		$display("test write mask and reset done");

		// Sparse random events keep most flags clear so set and clear both get exercised
		repeat (40) begin
			step(1'($urandom_range(1, 0)), 4'($urandom_range(2, 0)), 16'($urandom),
				16'($urandom & $urandom & $urandom), 16'($urandom & $urandom & $urandom));
			verify();
		end
		$display("test random traffic done");
		print_verdict();
	end
endmodule
